//--- opcode_classify.sv
// Opcode decode package and first-byte classifier
// Assumes bytes arrive from logic on the same clock; purely combinational
package opdec_pkg;
  // First-byte patterns and the ASCII second byte
  localparam logic [5:0] COPY_RM_PAT     = 6'h22;
  localparam logic [6:0] COPY_IMM_PAT    = 7'h63;
  localparam logic [7:0] COPY_TO_SEG     = 8'h8E;
  localparam logic [7:0] COPY_FROM_SEG   = 8'h8C;
  localparam logic [7:0] STACK_STORE_OP  = 8'hFF;
  localparam logic [7:0] STACK_LOAD_OP   = 8'h8F;
  localparam logic [6:0] MINUS_ONE_PAT   = 7'h7F;
  localparam logic [5:0] COMPARE_RM_PAT  = 6'h0E;
  localparam logic [6:0] COMPARE_ACC_PAT = 7'h1E;
  localparam logic [6:0] QUOT_PAT        = 7'h7B;
  localparam logic [7:0] ASCII_SUB_OP    = 8'h2F;
  localparam logic [7:0] ASCII_PROD_OP   = 8'hD4;
  localparam logic [7:0] ASCII_QUOT_OP   = 8'hD5;
  localparam logic [7:0] ASCII_BASE      = 8'h0A;
  localparam logic [7:0] BYTE_WIDEN_OP   = 8'h98;
  localparam logic [7:0] WORD_WIDEN_OP   = 8'h99;
  // Second-byte middle fields
  localparam logic [2:0] MID_COPY_IMM    = 3'h0;
  localparam logic [2:0] MID_STACK_STORE = 3'h6;
  localparam logic [2:0] MID_STACK_LOAD  = 3'h0;
  localparam logic [2:0] MID_MINUS_ONE   = 3'h1;
  localparam logic [2:0] MID_SIGN_FLIP   = 3'h3;
  localparam logic [2:0] MID_UQUOT       = 3'h6;
  localparam logic [2:0] MID_SQUOT       = 3'h7;
  // Field positions
  localparam int SIZE_BIT    = 0;
  localparam int DIR_BIT     = 1;
  localparam int SEG_TOP_BIT = 5;
  // Immediate byte counts
  localparam logic [1:0] IMM_NARROW = 2'h1;
  localparam logic [1:0] IMM_WIDE   = 2'h2;

  typedef enum logic [3:0] {
    ST_OPCODE = 4'h1,
    ST_MODRM  = 4'h2,
    ST_FIXED2 = 4'h4,
    ST_IMM    = 4'h8
  } state_t;

  typedef enum logic [4:0] {
    OP_NONE                 = 5'h00,
    OP_COPY_RM              = 5'h01,
    OP_COPY_IMM             = 5'h02,
    OP_COPY_TO_SEG          = 5'h03,
    OP_COPY_FROM_SEG        = 5'h04,
    OP_STACK_STORE          = 5'h05,
    OP_STACK_LOAD           = 5'h06,
    OP_MINUS_ONE            = 5'h07,
    OP_SIGN_FLIP            = 5'h08,
    OP_COMPARE_RM           = 5'h09,
    OP_COMPARE_ACC_IMM      = 5'h0A,
    OP_UNSIGNED_QUOTIENT    = 5'h0B,
    OP_SIGNED_QUOTIENT      = 5'h0C,
    OP_ASCII_SUBTRACT_FIX   = 5'h0D,
    OP_ASCII_PRODUCT_FIX    = 5'h0E,
    OP_ASCII_QUOTIENT_PREP  = 5'h0F,
    OP_BYTE_SIGN_WIDEN      = 5'h10,
    OP_WORD_SIGN_WIDEN      = 5'h11
  } op_t;

  typedef enum logic [2:0] {
    KIND_DONE   = 3'h0,
    KIND_FIXED  = 3'h1,
    KIND_SEG    = 3'h2,
    KIND_MID    = 3'h3,
    KIND_SECOND = 3'h4,
    KIND_IMM    = 3'h5,
    KIND_BAD    = 3'h6
  } kind_t;

  typedef struct packed {
    kind_t kind;
    op_t   op;
    logic  word;
    logic  reg_dest;
  } first_class_t;

  typedef struct packed {
    op_t         op;
    logic        unsupported;
    logic        word;
    logic        reg_dest;
    logic        has_operand_byte;
    logic [1:0]  mode;
    logic [2:0]  reg_field;
    logic [2:0]  rm_field;
    logic [15:0] imm;
  } decode_result_t;
endpackage

`timescale 1ns/1ns
module opcode_classify (
  // First byte
  input  wire logic [7:0]            byte_in,
  // Classification
  output opdec_pkg::first_class_t    class_out
);
  always_comb begin
    class_out          = '0;
    class_out.kind     = opdec_pkg::KIND_BAD;
    class_out.op       = opdec_pkg::OP_NONE;
    class_out.word     = byte_in[opdec_pkg::SIZE_BIT];
    class_out.reg_dest = 1'h0;
    if (byte_in[7:2] == opdec_pkg::COPY_RM_PAT) begin
      class_out.kind     = opdec_pkg::KIND_FIXED;
      class_out.op       = opdec_pkg::OP_COPY_RM;
      class_out.reg_dest = byte_in[opdec_pkg::DIR_BIT];
    end else if (byte_in[7:2] == opdec_pkg::COMPARE_RM_PAT) begin
      class_out.kind     = opdec_pkg::KIND_FIXED;
      class_out.op       = opdec_pkg::OP_COMPARE_RM;
      class_out.reg_dest = byte_in[opdec_pkg::DIR_BIT];
    end else if (byte_in == opdec_pkg::COPY_TO_SEG) begin
      class_out.kind     = opdec_pkg::KIND_SEG;
      class_out.op       = opdec_pkg::OP_COPY_TO_SEG;
      class_out.word     = 1'h1;
      class_out.reg_dest = 1'h1;
    end else if (byte_in == opdec_pkg::COPY_FROM_SEG) begin
      class_out.kind = opdec_pkg::KIND_SEG;
      class_out.op   = opdec_pkg::OP_COPY_FROM_SEG;
      class_out.word = 1'h1;
    end else if (byte_in[7:1] == opdec_pkg::COPY_IMM_PAT ||
                 byte_in[7:1] == opdec_pkg::MINUS_ONE_PAT ||
                 byte_in[7:1] == opdec_pkg::QUOT_PAT ||
                 byte_in == opdec_pkg::STACK_LOAD_OP) begin
      class_out.kind = opdec_pkg::KIND_MID;
    end else if (byte_in[7:1] == opdec_pkg::COMPARE_ACC_PAT) begin
      class_out.kind = opdec_pkg::KIND_IMM;
      class_out.op   = opdec_pkg::OP_COMPARE_ACC_IMM;
    end else if (byte_in == opdec_pkg::ASCII_PROD_OP) begin
      class_out.kind = opdec_pkg::KIND_SECOND;
      class_out.op   = opdec_pkg::OP_ASCII_PRODUCT_FIX;
    end else if (byte_in == opdec_pkg::ASCII_QUOT_OP) begin
      class_out.kind = opdec_pkg::KIND_SECOND;
      class_out.op   = opdec_pkg::OP_ASCII_QUOTIENT_PREP;
    end else if (byte_in == opdec_pkg::ASCII_SUB_OP) begin
      class_out.kind = opdec_pkg::KIND_DONE;
      class_out.op   = opdec_pkg::OP_ASCII_SUBTRACT_FIX;
    end else if (byte_in == opdec_pkg::BYTE_WIDEN_OP) begin
      class_out.kind = opdec_pkg::KIND_DONE;
      class_out.op   = opdec_pkg::OP_BYTE_SIGN_WIDEN;
    end else if (byte_in == opdec_pkg::WORD_WIDEN_OP) begin
      class_out.kind = opdec_pkg::KIND_DONE;
      class_out.op   = opdec_pkg::OP_WORD_SIGN_WIDEN;
    end
  end
endmodule

//--- opcode_decode_transfer_arith.sv
// Instruction decoder for copy, stack, compare, divide and adjust opcodes
// Assumes bytes come one per valid cycle from logic on ref_clk_in
// Notes on behaviour
// - 100010dw plus operand byte: register copy
// - 1100011w mid 000: immediate copy, bytes
// - 8E: copy into segment, top bit 0
// - 8C: copy from segment, top bit 0
// - FF mid 110: stack store
// - 8F mid 000: stack load
// - 1111111w mid 001: minus one
// - 001110dw: compare register with operand
// - 0011110w: compare accumulator with immediate
// - 1111011w mid 110: unsigned divide
// - 1111011w mid 111: signed divide
// - 2F: ASCII fix after subtract
// - D4 0A: ASCII fix after multiply
// - D5 0A: ASCII prep before divide
// - 98: widen byte sign into word
// - 99: widen word sign into double
`timescale 1ns/1ns
module opcode_decode_transfer_arith (
  // Clock and reset
  input  wire logic                      ref_clk_in,
  input  wire logic                      rst_b_in,
  // Instruction byte stream
  input  wire logic                      byte_valid_in,
  input  wire logic [7:0]                byte_in,
  // Decode result
  output logic                           result_valid_out,
  output opdec_pkg::decode_result_t      result_out,
  output logic                           mid_instr_out
);
  opdec_pkg::state_t         st_ff;
  opdec_pkg::state_t         nxt_st;
  opdec_pkg::decode_result_t res_ff;
  opdec_pkg::decode_result_t nxt_res;
  logic                      res_vld_ff;
  logic                      nxt_res_vld;
  logic [7:0]                first_ff;
  logic [7:0]                nxt_first;
  opdec_pkg::kind_t          kind_ff;
  opdec_pkg::kind_t          nxt_kind;
  logic [1:0]                left_ff;
  logic [1:0]                nxt_left;
  opdec_pkg::first_class_t   cls;
  opdec_pkg::op_t            mid_op;

  opcode_classify u_classify (
    .byte_in   (byte_in),
    .class_out (cls)
  );

  // Operation chosen by the middle field of the operand byte
  function automatic opdec_pkg::op_t mid_decode(input logic [7:0] first,
                                                input logic [2:0] mid);
    mid_decode = opdec_pkg::OP_NONE;
    if (first[7:1] == opdec_pkg::MINUS_ONE_PAT && mid == opdec_pkg::MID_MINUS_ONE) begin
      mid_decode = opdec_pkg::OP_MINUS_ONE;
    end else if (first == opdec_pkg::STACK_STORE_OP &&
                 mid == opdec_pkg::MID_STACK_STORE) begin
      mid_decode = opdec_pkg::OP_STACK_STORE;
    end else if (first == opdec_pkg::STACK_LOAD_OP &&
                 mid == opdec_pkg::MID_STACK_LOAD) begin
      mid_decode = opdec_pkg::OP_STACK_LOAD;
    end else if (first[7:1] == opdec_pkg::COPY_IMM_PAT && mid == opdec_pkg::MID_COPY_IMM) begin
      mid_decode = opdec_pkg::OP_COPY_IMM;
    end else if (first[7:1] == opdec_pkg::QUOT_PAT) begin
      if (mid == opdec_pkg::MID_UQUOT) begin
        mid_decode = opdec_pkg::OP_UNSIGNED_QUOTIENT;
      end else if (mid == opdec_pkg::MID_SQUOT) begin
        mid_decode = opdec_pkg::OP_SIGNED_QUOTIENT;
      end else if (mid == opdec_pkg::MID_SIGN_FLIP) begin
        mid_decode = opdec_pkg::OP_SIGN_FLIP;
      end
    end
  endfunction

  assign mid_op = mid_decode(first_ff, byte_in[5:3]);

  // Next-state and result assembly
  always_comb begin
    nxt_st      = st_ff;
    nxt_res     = res_ff;
    nxt_res_vld = 1'h0;
    nxt_first   = first_ff;
    nxt_kind    = kind_ff;
    nxt_left    = left_ff;
    if (byte_valid_in) begin
      unique case (st_ff)
        opdec_pkg::ST_OPCODE: begin
          nxt_first        = byte_in;
          nxt_kind         = cls.kind;
          nxt_res          = '0;
          nxt_res.op       = cls.op;
          nxt_res.word     = cls.word;
          nxt_res.reg_dest = cls.reg_dest;
          unique case (cls.kind)
            opdec_pkg::KIND_DONE: begin
              nxt_res_vld = 1'h1;
            end
            opdec_pkg::KIND_BAD: begin
              nxt_res.unsupported = 1'h1;
              nxt_res_vld         = 1'h1;
            end
            opdec_pkg::KIND_IMM: begin
              nxt_left = cls.word ? opdec_pkg::IMM_WIDE : opdec_pkg::IMM_NARROW;
              nxt_st   = opdec_pkg::ST_IMM;
            end
            opdec_pkg::KIND_SECOND: begin
              nxt_st = opdec_pkg::ST_FIXED2;
            end
            default: begin
              nxt_st = opdec_pkg::ST_MODRM;
            end
          endcase
        end
        opdec_pkg::ST_MODRM: begin
          nxt_res.has_operand_byte = 1'h1;
          nxt_res.mode             = byte_in[7:6];
          nxt_res.reg_field        = byte_in[5:3];
          nxt_res.rm_field         = byte_in[2:0];
          nxt_st                   = opdec_pkg::ST_OPCODE;
          nxt_res_vld              = 1'h1;
          if (kind_ff == opdec_pkg::KIND_SEG && byte_in[opdec_pkg::SEG_TOP_BIT]) begin
            nxt_res.unsupported = 1'h1;
          end
          if (kind_ff == opdec_pkg::KIND_MID) begin
            nxt_res.op = mid_op;
            if (mid_op == opdec_pkg::OP_NONE) begin
              nxt_res.unsupported = 1'h1;
            end
            if (mid_op == opdec_pkg::OP_COPY_IMM) begin
              nxt_left    = res_ff.word ? opdec_pkg::IMM_WIDE : opdec_pkg::IMM_NARROW;
              nxt_st      = opdec_pkg::ST_IMM;
              nxt_res_vld = 1'h0;
            end
          end
        end
        opdec_pkg::ST_FIXED2: begin
          if (byte_in != opdec_pkg::ASCII_BASE) begin
            nxt_res.unsupported = 1'h1;
          end
          nxt_st      = opdec_pkg::ST_OPCODE;
          nxt_res_vld = 1'h1;
        end
        opdec_pkg::ST_IMM: begin
          // Low byte first, high byte second
          if (res_ff.word) begin
            nxt_res.imm = {byte_in, res_ff.imm[15:8]};
          end else begin
            nxt_res.imm = {8'h00, byte_in};
          end
          nxt_left = left_ff - 2'h1;
          if (left_ff == opdec_pkg::IMM_NARROW) begin
            nxt_st      = opdec_pkg::ST_OPCODE;
            nxt_res_vld = 1'h1;
          end
        end
        default: begin
          nxt_st = opdec_pkg::ST_OPCODE;
        end
      endcase
    end
  end

  // Sequencer state
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_ff   <= opdec_pkg::ST_OPCODE;
      kind_ff <= opdec_pkg::KIND_DONE;
      left_ff <= 2'h0;
    end else begin
      st_ff   <= nxt_st;
      kind_ff <= nxt_kind;
      left_ff <= nxt_left;
    end
  end

  // First byte held for operand-byte decode
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      first_ff <= 8'h00;
    end else begin
      first_ff <= nxt_first;
    end
  end

  // Result registers
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      res_ff     <= '0;
      res_vld_ff <= 1'h0;
    end else begin
      res_ff     <= nxt_res;
      res_vld_ff <= nxt_res_vld;
    end
  end

  // Busy flag
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mid_instr_out <= 1'h0;
    end else begin
      mid_instr_out <= (nxt_st != opdec_pkg::ST_OPCODE);
    end
  end

  assign result_valid_out = res_vld_ff;
  assign result_out       = res_ff;

  // Checks
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  sequence s_opcode_taken;
    st_ff == opdec_pkg::ST_OPCODE && byte_valid_in;
  endsequence

  sequence s_modrm_taken;
    st_ff == opdec_pkg::ST_MODRM && byte_valid_in;
  endsequence

  sequence s_copy_rm_pair;
    (s_opcode_taken ##0 byte_in[7:2] == opdec_pkg::COPY_RM_PAT) ##1 s_modrm_taken;
  endsequence

  AST_COPY_RM_FIELDS: assert property (
    s_copy_rm_pair |=> res_vld_ff && res_ff.op == opdec_pkg::OP_COPY_RM &&
      res_ff.reg_field == $past(byte_in[5:3]) && res_ff.reg_dest == $past(byte_in[1], 2) &&
      res_ff.word == $past(byte_in[0], 2))
    else $error("copy operand fields wrong");

  AST_IMM_COPY_COUNT: assert property (
    s_modrm_taken ##0 (kind_ff == opdec_pkg::KIND_MID &&
      first_ff[7:1] == opdec_pkg::COPY_IMM_PAT && byte_in[5:3] == opdec_pkg::MID_COPY_IMM)
    |=> st_ff == opdec_pkg::ST_IMM && !res_vld_ff &&
      left_ff == (first_ff[0] ? opdec_pkg::IMM_WIDE : opdec_pkg::IMM_NARROW))
    else $error("immediate copy byte count wrong");

  AST_SEG_TOP_BIT: assert property (
    s_modrm_taken ##0 (kind_ff == opdec_pkg::KIND_SEG) |=>
      res_vld_ff && res_ff.unsupported == $past(byte_in[5]))
    else $error("segment selector top bit not checked");

  AST_SEG_TO: assert property (
    (s_opcode_taken ##0 byte_in == opdec_pkg::COPY_TO_SEG) ##1 (s_modrm_taken ##0 !byte_in[5])
    |=> res_vld_ff && res_ff.op == opdec_pkg::OP_COPY_TO_SEG && !res_ff.unsupported)
    else $error("copy into segment not decoded");

  AST_SEG_FROM: assert property (
    (s_opcode_taken ##0 byte_in == opdec_pkg::COPY_FROM_SEG) ##1 s_modrm_taken
    |=> res_vld_ff && res_ff.op == opdec_pkg::OP_COPY_FROM_SEG)
    else $error("copy from segment not decoded");

  AST_STACK: assert property (
    s_modrm_taken ##0 (kind_ff == opdec_pkg::KIND_MID &&
      ((first_ff == opdec_pkg::STACK_STORE_OP && byte_in[5:3] == opdec_pkg::MID_STACK_STORE) ||
       (first_ff == opdec_pkg::STACK_LOAD_OP && byte_in[5:3] == opdec_pkg::MID_STACK_LOAD)))
    |=> res_vld_ff && !res_ff.unsupported &&
      (res_ff.op == opdec_pkg::OP_STACK_STORE || res_ff.op == opdec_pkg::OP_STACK_LOAD))
    else $error("stack operand form not decoded");

  AST_MINUS_ONE: assert property (
    (s_opcode_taken ##0 byte_in[7:1] == opdec_pkg::MINUS_ONE_PAT) ##1
      (s_modrm_taken ##0 byte_in[5:3] == opdec_pkg::MID_MINUS_ONE)
    |=> res_vld_ff && res_ff.op == opdec_pkg::OP_MINUS_ONE && res_ff.word == $past(first_ff[0]))
    else $error("minus one not decoded");

  AST_COMPARE_RM: assert property (
    s_opcode_taken ##0 byte_in[7:2] == opdec_pkg::COMPARE_RM_PAT
    |=> st_ff == opdec_pkg::ST_MODRM && res_ff.op == opdec_pkg::OP_COMPARE_RM)
    else $error("compare register form not pending");

  AST_COMPARE_ACC: assert property (
    (s_opcode_taken ##0 byte_in == {opdec_pkg::COMPARE_ACC_PAT, 1'h1}) ##1 byte_valid_in[*2]
    |=> res_vld_ff && res_ff.op == opdec_pkg::OP_COMPARE_ACC_IMM &&
      res_ff.imm == {$past(byte_in), $past(byte_in, 2)})
    else $error("accumulator compare immediate wrong");

  AST_DIVIDE: assert property (
    s_modrm_taken ##0 (kind_ff == opdec_pkg::KIND_MID && first_ff[7:1] == opdec_pkg::QUOT_PAT &&
      byte_in[5:4] == 2'h3)
    |=> res_vld_ff && res_ff.op == ($past(byte_in[3]) ? opdec_pkg::OP_SIGNED_QUOTIENT :
      opdec_pkg::OP_UNSIGNED_QUOTIENT))
    else $error("divide form not decoded");

  AST_ASCII_PAIR: assert property (
    st_ff == opdec_pkg::ST_FIXED2 && byte_valid_in |=>
      res_vld_ff && res_ff.unsupported == ($past(byte_in) != opdec_pkg::ASCII_BASE))
    else $error("adjust second byte not checked");

  AST_SINGLE_BYTE: assert property (
    s_opcode_taken ##0 (byte_in == opdec_pkg::ASCII_SUB_OP ||
      byte_in == opdec_pkg::BYTE_WIDEN_OP || byte_in == opdec_pkg::WORD_WIDEN_OP)
    |=> res_vld_ff && !res_ff.unsupported && st_ff == opdec_pkg::ST_OPCODE)
    else $error("single byte op not completed");

  AST_BAD_FIRST: assert property (
    s_opcode_taken ##0 (cls.kind == opdec_pkg::KIND_BAD) |=>
      res_vld_ff && res_ff.unsupported && res_ff.op == opdec_pkg::OP_NONE)
    else $error("unknown opcode not flagged");

  AST_IMM_HOLD: assert property (
    st_ff == opdec_pkg::ST_IMM && !byte_valid_in |=> st_ff == opdec_pkg::ST_IMM && !res_vld_ff)
    else $error("immediate wait lost");
endmodule

//--- instr_feeder.sv
// Model of program memory handing instruction bytes to the decoder
// Assumes one clock; bytes are queued by the bench and leave at most one per cycle
`timescale 1ns/1ns
module instr_feeder (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_b_in,
  // Pace control
  input  wire logic       slow_in,
  // Byte stream
  output logic            byte_valid_out,
  output logic [7:0]      byte_out,
  output logic            idle_out
);
  logic [7:0] pending[$];
  logic       gap_ff;

  initial begin
    byte_valid_out = 1'b0;
    byte_out       = 8'h00;
    idle_out       = 1'b1;
    gap_ff         = 1'b0;
  end

  task automatic push(input logic [7:0] b);
    pending.push_back(b);
    idle_out = 1'b0;
  endtask

  // Slow pace inserts a gap every other cycle
  always @(posedge clk_in) begin
    #2;
    gap_ff = slow_in & ~gap_ff;
    if (rst_b_in === 1'b1 && pending.size() > 0 && !gap_ff) begin
      byte_valid_out = 1'b1;
      byte_out       = pending.pop_front();
    end else begin
      // Released line inverts the last byte each idle cycle, so the stale byte returns every second idle cycle
      byte_valid_out = 1'b0;
      byte_out       = ~byte_out;
    end
    idle_out = (pending.size() == 0) && !byte_valid_out;
  end
endmodule

//--- tb_opcode_decode_transfer_arith.sv
// Self-checking bench for the opcode decoder
// Assumes opdec_pkg and the decoder are compiled ahead of this file
`timescale 1ns/1ns
module tb_opcode_decode_transfer_arith;
  typedef struct packed {
    opdec_pkg::decode_result_t r;
    logic                      full;
    logic [15:0]               imask;
  } expect_t;

  logic                      ref_clk_in = 1'b0;
  logic                      rst_b_in   = 1'b0;
  logic                      slow       = 1'b0;
  logic                      byte_valid;
  logic [7:0]                byte_w;
  logic                      idle;
  logic                      result_valid;
  opdec_pkg::decode_result_t result;
  logic                      mid_instr;
  int                        fail_count = 0;
  int                        samples_checked = 0;
  logic [31:0]               seed = 32'h0000C3B1;
  expect_t                   exp_q[$];
  logic [7:0]                firsts[26] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'hC6, 8'hC7, 8'h8E,
    8'h8C, 8'hFF, 8'hFE, 8'h8F, 8'h38, 8'h39, 8'h3A, 8'h3B, 8'h3C, 8'h3D, 8'hF6, 8'hF7,
    8'h2F, 8'hD4, 8'hD5, 8'h98, 8'h99, 8'h0F, 8'h00};

  always #25 ref_clk_in = ~ref_clk_in;

  instr_feeder instr_feeder_i (
    .clk_in         (ref_clk_in),
    .rst_b_in       (rst_b_in),
    .slow_in        (slow),
    .byte_valid_out (byte_valid),
    .byte_out       (byte_w),
    .idle_out       (idle)
  );

  opcode_decode_transfer_arith opcode_decode_transfer_arith_i (
    .ref_clk_in       (ref_clk_in),
    .rst_b_in         (rst_b_in),
    .byte_valid_in    (byte_valid),
    .byte_in          (byte_w),
    .result_valid_out (result_valid),
    .result_out       (result),
    .mid_instr_out    (mid_instr)
  );

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Expected decode and byte count of one instruction
  function automatic expect_t predict(input logic [7:0] b0, b1, b2, b3, output int n);
    expect_t    e;
    logic [2:0] mid;
    e = '0;
    mid = b1[5:3];
    n = 2;
    e.full = 1'b1;
    e.r.word = b0[0];
    e.r.mode = b1[7:6];
    e.r.reg_field = mid;
    e.r.rm_field = b1[2:0];
    e.r.has_operand_byte = 1'b1;
    if (b0[7:2] == opdec_pkg::COPY_RM_PAT || b0[7:2] == opdec_pkg::COMPARE_RM_PAT) begin
      e.r.op = b0[7] ? opdec_pkg::OP_COPY_RM : opdec_pkg::OP_COMPARE_RM;
      e.r.reg_dest = b0[1];
    end else if (b0[7:1] == opdec_pkg::COPY_IMM_PAT) begin
      e.r.op = opdec_pkg::OP_COPY_IMM;
      n = b0[0] ? 4 : 3;
      e.r.imm = {b3, b2};
      e.imask = b0[0] ? 16'hFFFF : 16'h00FF;
    end else if (b0 == opdec_pkg::COPY_TO_SEG || b0 == opdec_pkg::COPY_FROM_SEG) begin
      e.r.op = b0[1] ? opdec_pkg::OP_COPY_TO_SEG : opdec_pkg::OP_COPY_FROM_SEG;
      e.r.word = 1'b1;
      e.r.reg_dest = b0[1];
      e.r.unsupported = b1[5];
    end else if (b0 == opdec_pkg::STACK_LOAD_OP) begin
      e.r.op = opdec_pkg::OP_STACK_LOAD;
      e.r.unsupported = (mid != 3'h0);
    end else if (b0[7:1] == opdec_pkg::MINUS_ONE_PAT) begin
      e.r.op = (mid == 3'h1) ? opdec_pkg::OP_MINUS_ONE :
               (b0[0] && mid == 3'h6) ? opdec_pkg::OP_STACK_STORE : opdec_pkg::OP_NONE;
      e.r.unsupported = (e.r.op == opdec_pkg::OP_NONE);
    end else if (b0[7:1] == opdec_pkg::QUOT_PAT) begin
      e.r.op = (mid == 3'h3) ? opdec_pkg::OP_SIGN_FLIP :
               (mid == 3'h6) ? opdec_pkg::OP_UNSIGNED_QUOTIENT :
               (mid == 3'h7) ? opdec_pkg::OP_SIGNED_QUOTIENT : opdec_pkg::OP_NONE;
      e.r.unsupported = (e.r.op == opdec_pkg::OP_NONE);
    end else if (b0[7:1] == opdec_pkg::COMPARE_ACC_PAT) begin
      e.r.op = opdec_pkg::OP_COMPARE_ACC_IMM;
      e.r.has_operand_byte = 1'b0;
      n = b0[0] ? 3 : 2;
      e.r.imm = {b2, b1};
      e.imask = b0[0] ? 16'hFFFF : 16'h00FF;
    end else begin
      n = 1;
      e.full = 1'b0;
      e.r.has_operand_byte = 1'b0;
      case (b0)
        8'h2F: e.r.op = opdec_pkg::OP_ASCII_SUBTRACT_FIX;
        8'h98: e.r.op = opdec_pkg::OP_BYTE_SIGN_WIDEN;
        8'h99: e.r.op = opdec_pkg::OP_WORD_SIGN_WIDEN;
        8'hD4, 8'hD5: begin
          n = 2;
          e.r.op = b0[0] ? opdec_pkg::OP_ASCII_QUOTIENT_PREP : opdec_pkg::OP_ASCII_PRODUCT_FIX;
          e.r.unsupported = (b1 != opdec_pkg::ASCII_BASE);
        end
        default: e.r.unsupported = 1'b1;
      endcase
    end
    if (e.r.unsupported) begin
      e.full = 1'b0;
      e.imask = 16'h0000;
    end
    return e;
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic send(input logic [7:0] b0, b1, b2, b3);
    logic [7:0] bs[4];
    int         n;
    bs = '{b0, b1, b2, b3};
    exp_q.push_back(predict(b0, b1, b2, b3, n));
    for (int i = 0; i < n; i++) instr_feeder_i.push(bs[i]);
  endtask

  task automatic drain();
    for (int i = 0; i < 400 && idle !== 1'b1; i++) @(posedge ref_clk_in);
    check(16'(idle), 16'h0001);
    repeat (3) @(posedge ref_clk_in);
    check(16'(exp_q.size()), 16'h0000);
  endtask

  task automatic wrap_up();
    $display("checked %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare each finished decode with the prediction
  always @(negedge ref_clk_in) begin : monitor
    expect_t e;
    if (rst_b_in === 1'b1 && result_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check(16'h0001, 16'h0000);
      end else begin
        e = exp_q.pop_front();
        check(16'(result.unsupported), 16'(e.r.unsupported));
        if (!e.r.unsupported || !e.r.has_operand_byte)
          check(16'(result.op), 16'(e.r.op));
        if (e.full) begin
          check(16'(result.word), 16'(e.r.word));
          check(16'(result.reg_dest), 16'(e.r.reg_dest));
          check(16'(result.has_operand_byte), 16'(e.r.has_operand_byte));
        end
        if (e.full && e.r.has_operand_byte)
          check({result.mode, result.reg_field, result.rm_field},
                {e.r.mode, e.r.reg_field, e.r.rm_field});
        check(result.imm & e.imask, e.r.imm & e.imask);
      end
    end
  end

  initial begin
    #2_000_000;
    fail_count++;
    wrap_up();
  end

  initial begin
    logic [7:0] b0;
    logic [7:0] b1;
    repeat (20) @(posedge ref_clk_in);
    #2 rst_b_in = 1'b1;
    // Corner cases
    send(8'h89, 8'hC8, 8'h00, 8'h00);
    send(8'h98, 8'h00, 8'h00, 8'h00);
    send(8'h3D, 8'h34, 8'h12, 8'h00);
    send(8'h8E, 8'hE8, 8'h00, 8'h00);
    send(8'h8C, 8'h18, 8'h00, 8'h00);
    send(8'hD4, 8'h0A, 8'h00, 8'h00);
    send(8'hD5, 8'h0B, 8'h00, 8'h00);
    send(8'h0F, 8'h00, 8'h00, 8'h00);
    send(8'hC7, 8'h05, 8'hCD, 8'hAB);
    drain();
    // Random batches at both paces
    for (int k = 0; k < 40; k++) begin
      slow = 1'(rnd());
      for (int j = 0; j < 10; j++) begin
        b0 = firsts[rnd() % 26];
        b1 = 8'(rnd());
        if (b0[7:1] == opdec_pkg::COPY_IMM_PAT) b1[5:3] = 3'h0;
        if ((b0 == 8'hD4 || b0 == 8'hD5) && rnd() & 32'h1) b1 = opdec_pkg::ASCII_BASE;
        send(b0, b1, 8'(rnd()), 8'(rnd()));
      end
      drain();
    end
    // Reset in mid-instruction drops the partial decode
    instr_feeder_i.push(8'h89);
    drain();
    @(negedge ref_clk_in);
    check(16'(mid_instr), 16'h0001);
    @(posedge ref_clk_in);
    #2 rst_b_in = 1'b0;
    repeat (2) @(posedge ref_clk_in);
    #2 rst_b_in = 1'b1;
    @(negedge ref_clk_in);
    check(16'({mid_instr, result_valid}), 16'h0000);
    send(8'h99, 8'h00, 8'h00, 8'h00);
    drain();
    wrap_up();
  end
endmodule
